// >>> design/dag_consts.svh
// Register offsets, field positions, reset values and encodings for the address generator
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH
`define DAG_OFS_SRC 3'h0
`define DAG_OFS_DST 3'h1
`define DAG_OFS_CFG 3'h2
`define DAG_OFS_CTL 3'h3
`define DAG_OFS_STAT 3'h4
`define DAG_CFG_WIDTH_LO 26
`define DAG_CFG_WIDTH_HI 27
`define DAG_CFG_FIX_SRC 25
`define DAG_CFG_FIX_DST 24
`define DAG_CFG_RELOAD_SRC 22
`define DAG_CFG_RELOAD_DST 21
`define DAG_CTL_START 0
`define DAG_CTL_STOP 1
`define DAG_ADDR_RESET 32'h00000000
`define DAG_CFG_RESET 32'h00000000
`define DAG_WIDTH_8 2'h0
`define DAG_WIDTH_16 2'h1
`define DAG_WIDTH_32 2'h2
`define DAG_STEP_8 32'h00000001
`define DAG_STEP_16 32'h00000002
`define DAG_STEP_32 32'h00000004
`define DAG_STEP_NONE 32'h00000000
`endif

// >>> design/dag_pkg.sv
// Types shared by the address generator files
package dag_pkg;
  typedef enum logic [1:0] {
    DAG_IDLE = 2'b00,
    DAG_RUN = 2'b01
  } dag_state_t;
  typedef logic [31:0] dag_word_t;
endpackage

// >>> design/dag_addr_unit.sv
// One address lane: fixed or stepping address, shadow start value and reload
`timescale 1ns/1ps
`include "dag_consts.svh"
module dag_addr_unit
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wr_be,
  input wire dag_pkg::dag_word_t wr_data,
  input wire logic start,
  input wire logic beat,
  input wire logic done_ok,
  input wire logic fixed,
  input wire logic reload,
  input wire dag_pkg::dag_word_t step,
  output dag_pkg::dag_word_t addr
);
  import dag_pkg::*;
  dag_word_t addr_q; // Live address
  dag_word_t addr_d;
  dag_word_t shadow_q; // Start value kept for reload
  dag_word_t shadow_d;
  logic done_q; // Completion seen last cycle; reload follows the final step
  logic done_d;
  // Next address and shadow
  always_comb
  begin
    addr_d = addr_q;
    shadow_d = shadow_q;
    done_d = done_ok;
    if (start)
    begin
      shadow_d = addr_q; // R15
    end
    if (beat && !fixed)
    begin
      // Fixed mode never steps or reloads the register; bus writes still land
      addr_d = addr_q + step; // R5 R3 R4
    end
    else if (done_q && !fixed && reload)
    begin
      addr_d = shadow_q; // R6
    end
    // Byte lane writes; software is trusted not to write mid transfer
    for (int i = 0; i < 4; i++)
    begin
      if (wr_be[i])
      begin
        addr_d[i*8 +: 8] = wr_data[i*8 +: 8]; // R8
      end
    end
  end
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= `DAG_ADDR_RESET; // R1 R2
      shadow_q <= `DAG_ADDR_RESET;
      done_q <= 1'b0;
    end
    else
    begin
      addr_q <= addr_d;
      shadow_q <= shadow_d;
      done_q <= done_d;
    end
  end
  assign addr = addr_q;
endmodule

// >>> design/dag_top.sv
// Address generator of one DMA channel with an Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "dag_consts.svh"
// How it works
// (R1) Source address 32-bit, readable, resets zero
// (R2) Destination address 32-bit, readable, resets zero
// (R3) Fixed source keeps source register unchanged
// (R4) Fixed destination keeps destination register unchanged
// (R5) Non-reload address steps each beat, stays
// (R6) Reload restores start value at completion
// (R7) Software must program width-aligned addresses
// (R8) Registers accept byte, half and word
// (R9) Software avoids controller register space addresses
// (R10) Software leaves settings alone while active
// (R11) Software halts, checks stopped before sleep
// (R12) Software never targets bit-band alias region
// (R13) Width code 00/01/10, 11 reserved
// (R14) Step is 1, 2 or 4 bytes
// (R15) Start values shadowed when transfer begins
module dag_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic beat_done,
  input wire logic last_beat,
  input wire logic abort,
  output logic busy,
  output dag_pkg::dag_word_t src_addr,
  output dag_pkg::dag_word_t dst_addr,
  output logic [1:0] beat_width
);
  import dag_pkg::*;
  // Step in bytes for a width code; reserved code gives no step
  function automatic dag_word_t width_step(input logic [1:0] w);
    case (w)
      `DAG_WIDTH_8: width_step = `DAG_STEP_8; // R13 R14
      `DAG_WIDTH_16: width_step = `DAG_STEP_16; // R14
      `DAG_WIDTH_32: width_step = `DAG_STEP_32; // R14
      default: width_step = `DAG_STEP_NONE;
    endcase
  endfunction
  // Byte enables masked to a given register
  function automatic logic [3:0] lane_hit(input logic [2:0] a, input logic [2:0] ofs,
                                          input logic wr, input logic [3:0] be);
    lane_hit = (wr && a == ofs) ? be : 4'h0;
  endfunction
  dag_state_t state_q; // Channel run state
  dag_state_t state_d;
  dag_word_t cfg_q; // Configuration word
  dag_word_t cfg_d;
  logic ack_q; // Answer phase of a bus access
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] end_code_q; // 0 none, 1 complete, 2 stopped
  logic [1:0] end_code_d;
  logic busy_q;
  logic busy_d;
  logic [1:0] width_q;
  logic [1:0] width_d;
  logic req;
  logic acc;
  logic [3:0] be_src;
  logic [3:0] be_dst;
  logic start_pulse;
  logic stop_pulse;
  logic beat_pulse;
  logic done_ok;
  dag_word_t step;
  dag_word_t src_w;
  dag_word_t dst_w;
  logic fix_source;
  logic fix_dest;
  logic reload_src;
  logic reload_dst;
  // One wait cycle per access; taken at the edge where waitrequest is low
  assign req = avs_read || avs_write;
  assign acc = req && ack_q;
  assign be_src = lane_hit(avs_address, `DAG_OFS_SRC, avs_write && acc, avs_byteenable);
  assign be_dst = lane_hit(avs_address, `DAG_OFS_DST, avs_write && acc, avs_byteenable);
  assign start_pulse = avs_write && acc && avs_address == `DAG_OFS_CTL
                       && avs_byteenable[0] && avs_writedata[`DAG_CTL_START];
  assign stop_pulse = avs_write && acc && avs_address == `DAG_OFS_CTL
                      && avs_byteenable[0] && avs_writedata[`DAG_CTL_STOP];
  assign fix_source = cfg_q[`DAG_CFG_FIX_SRC];
  assign fix_dest = cfg_q[`DAG_CFG_FIX_DST];
  assign reload_src = cfg_q[`DAG_CFG_RELOAD_SRC];
  assign reload_dst = cfg_q[`DAG_CFG_RELOAD_DST];
  assign step = width_step(cfg_q[`DAG_CFG_WIDTH_HI:`DAG_CFG_WIDTH_LO]);
  // Beats only count while running; an abort wins over its own beat
  assign beat_pulse = state_q == DAG_RUN && beat_done && !abort && !stop_pulse;
  assign done_ok = beat_pulse && last_beat;
  // Source lane
  dag_addr_unit u_src
  (
    .clk(clk),
    .rst(rst),
    .wr_be(be_src),
    .wr_data(avs_writedata),
    .start(start_pulse && state_q == DAG_IDLE),
    .beat(beat_pulse),
    .done_ok(done_ok),
    .fixed(fix_source),
    .reload(reload_src),
    .step(step),
    .addr(src_w)
  );
  // Destination lane
  dag_addr_unit u_dst
  (
    .clk(clk),
    .rst(rst),
    .wr_be(be_dst),
    .wr_data(avs_writedata),
    .start(start_pulse && state_q == DAG_IDLE),
    .beat(beat_pulse),
    .done_ok(done_ok),
    .fixed(fix_dest),
    .reload(reload_dst),
    .step(step),
    .addr(dst_w)
  );
  // Run state; the final beat's step lands first, reload a cycle later
  always_comb
  begin
    state_d = state_q;
    end_code_d = end_code_q;
    case (state_q)
      DAG_IDLE:
      begin
        if (start_pulse)
        begin
          state_d = DAG_RUN;
          end_code_d = 2'h0;
        end
      end
      DAG_RUN:
      begin
        if (abort || stop_pulse)
        begin
          state_d = DAG_IDLE; // R5
          end_code_d = 2'h2;
        end
        else if (done_ok)
        begin
          state_d = DAG_IDLE;
          end_code_d = 2'h1;
        end
      end
      default: state_d = DAG_IDLE;
    endcase
  end
  // Bus answer, config and readback
  always_comb
  begin
    ack_d = req && !ack_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (avs_write && acc && avs_address == `DAG_OFS_CFG)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable[i])
        begin
          cfg_d[i*8 +: 8] = avs_writedata[i*8 +: 8]; // R8
        end
      end
    end
    if (avs_read && !ack_q)
    begin
      case (avs_address)
        `DAG_OFS_SRC: rdata_d = src_w; // R1
        `DAG_OFS_DST: rdata_d = dst_w; // R2
        `DAG_OFS_CFG: rdata_d = cfg_q;
        `DAG_OFS_STAT: rdata_d = {29'h0, end_code_q, state_q == DAG_RUN};
        default: rdata_d = 32'h00000000; // Unmapped and control read zero
      endcase
    end
    busy_d = state_d == DAG_RUN;
    width_d = cfg_d[`DAG_CFG_WIDTH_HI:`DAG_CFG_WIDTH_LO];
  end
  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= DAG_IDLE;
      cfg_q <= `DAG_CFG_RESET; // R13
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      end_code_q <= 2'h0;
      busy_q <= 1'b0;
      width_q <= `DAG_WIDTH_8;
    end
    else
    begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      end_code_q <= end_code_d;
      busy_q <= busy_d;
      width_q <= width_d;
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = !ack_q;
  assign busy = busy_q;
  assign beat_width = width_q;
  assign src_addr = src_w;
  assign dst_addr = dst_w;
endmodule

// >>> tb/dag_beat_src.sv
// Far-side model: reports finished beats, the final beat or an abort
`timescale 1ns/1ps
module dag_beat_src
(
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] beats,
  input wire logic kill,
  output logic beat_done,
  output logic last_beat,
  output logic abort
);
  initial
  begin
    beat_done = 1'h0;
    last_beat = 1'h0;
    abort = 1'h0;
  end
  // Gaps alternate short and long, so answers come promptly and slowly
  always @(posedge clk)
  begin
    if (go)
    begin
      for (int i = 1; i <= beats; i++)
      begin
        repeat (i[0] ? 1 : 3) @(posedge clk);
        beat_done <= 1'h1;
        last_beat <= (i == beats) && !kill;
        @(posedge clk);
        beat_done <= 1'h0;
        last_beat <= 1'h0;
      end
      // Abort stands alone, never with a beat
      if (kill)
      begin
        abort <= 1'h1;
        @(posedge clk);
        abort <= 1'h0;
      end
    end
  end
endmodule

// >>> tb/dag_top_props.sv
// Port-level checker for the address generator
`timescale 1ns/1ps
module dag_top_props
(
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic beat_done,
  input wire logic last_beat,
  input wire logic abort,
  input wire logic busy,
  input wire dag_pkg::dag_word_t src_addr,
  input wire dag_pkg::dag_word_t dst_addr,
  input wire logic [1:0] beat_width
);
  import dag_pkg::*;
  // Expected step from the width code; reserved code steps nothing
  dag_word_t step_w;
  always_comb step_w = (beat_width == 2'h3) ? 32'h0 : (32'h1 << beat_width);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_VAL: assert property ($fell(rst) |-> src_addr == 32'h0 && dst_addr == 32'h0)
    else $error("addresses not zero after reset");
  AST_RST_WID: assert property ($fell(rst) |-> beat_width == 2'h0 && !busy)
    else $error("width or busy wrong after reset");
  AST_ACK: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access not answered after one cycle");
  AST_SRC_STEP: assert property (busy && beat_done && !abort && !avs_write |=>
    src_addr == $past(src_addr) + $past(step_w) || $stable(src_addr))
    else $error("source moved by a wrong amount");
  AST_DST_STEP: assert property (busy && beat_done && !abort && !avs_write |=>
    dst_addr == $past(dst_addr) + $past(step_w) || $stable(dst_addr))
    else $error("destination moved by a wrong amount");
  AST_IDLE: assert property (!busy && !$past(busy) && !avs_write |=>
    $stable(src_addr) && $stable(dst_addr))
    else $error("address changed while idle");
  AST_END: assert property (busy && beat_done && last_beat |=> !busy)
    else $error("still busy after final beat");
  AST_ABORT: assert property (busy && abort && !beat_done && !avs_write |=>
    !busy ##1 $stable(src_addr) && $stable(dst_addr))
    else $error("abort did not hold addresses");
endmodule
bind dag_top dag_top_props u_props (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .beat_done, .last_beat, .abort, .busy, .src_addr, .dst_addr, .beat_width);

// >>> tb/dma_channel_address_generator_bench.sv
// Register and transfer tests for the address generator
`timescale 1ns/1ps
module dma_channel_address_generator_bench;
  import dag_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  dag_word_t avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  dag_word_t avs_readdata;
  logic avs_waitrequest;
  logic beat_done;
  logic last_beat;
  logic abort;
  logic busy;
  dag_word_t src_addr;
  dag_word_t dst_addr;
  dag_word_t rdv;
  logic [1:0] beat_width;
  logic go = 1'h0;
  logic kill = 1'h0;
  logic [3:0] beats = 4'h0;
  int err_total = 0;
  int checked = 0;
  dag_top u_dag_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .beat_done, .last_beat, .abort,
    .busy, .src_addr, .dst_addr, .beat_width);
  dag_beat_src u_dag_beat_src (.clk, .go, .beats, .kill, .beat_done, .last_beat, .abort);
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input dag_word_t e, input dag_word_t g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // One bus access; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [2:0] a, input dag_word_t d, input logic [3:0] b);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 20);
    if (avs_waitrequest !== 1'h0)
      conclude_late();
    rdv = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic conclude_late();
    err_total++;
    conclude();
  endtask
  task automatic rc(input logic [2:0] a, input dag_word_t e, input string nm);
    acc(1'h0, a, 32'h0, 4'hF);
    cmp(nm, e, rdv);
  endtask
  // Program aligned addresses outside controller space, start, wait idle
  task automatic run(input dag_word_t cfg, input logic [3:0] n, input logic k);
    int t;
    acc(1'h1, 3'h0, 32'h100, 4'hF);
    acc(1'h1, 3'h1, 32'h200, 4'hF);
    acc(1'h1, 3'h2, cfg, 4'hF);
    acc(1'h1, 3'h3, 32'h1, 4'hF);
    beats <= n;
    kill <= k;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    t = 0;
    do
    begin
      @(negedge clk);
      t++;
    end
    while (busy !== 1'h0 && t < 60);
    if (busy !== 1'h0)
      conclude_late();
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rc(3'h0, 32'h0, "src reset");
    rc(3'h1, 32'h0, "dst reset");
    rc(3'h2, 32'h0, "cfg reset");
    rc(3'h5, 32'h0, "unmapped");
    $display("test reset done");
    acc(1'h1, 3'h0, 32'h11223344, 4'hF);
    acc(1'h1, 3'h0, 32'h0000AA00, 4'h2);
    rc(3'h0, 32'h1122AA44, "src byte");
    acc(1'h1, 3'h1, 32'h55660000, 4'hC);
    rc(3'h1, 32'h55660000, "dst half");
    acc(1'h1, 3'h2, 32'h0A000000, 4'h8);
    rc(3'h2, 32'h0A000000, "cfg byte");
    cmp("width port", 32'h2, beat_width);
    rc(3'h3, 32'h0, "ctl read");
    $display("test lanes done");
    for (int w = 0; w < 3; w++)
    begin
      run({4'h0, w[1:0], 26'h0}, 4'h3, 1'h0);
      rc(3'h0, 32'h100 + 3 * (1 << w), "src step");
      rc(3'h1, 32'h200 + 3 * (1 << w), "dst step");
    end
    $display("test widths done");
    run(32'h0A200000, 4'h4, 1'h0);
    rc(3'h0, 32'h100, "src fixed");
    rc(3'h1, 32'h200, "dst reload");
    rc(3'h4, 32'h2, "status ok");
    run(32'h09400000, 4'h2, 1'h1);
    rc(3'h0, 32'h108, "src abort");
    rc(3'h1, 32'h200, "dst fixed");
    rc(3'h4, 32'h4, "status stopped");
    cmp("src port", 32'h108, src_addr);
    cmp("busy port", 32'h0, busy);
    $display("test fix reload abort done");
    conclude();
  end
endmodule
